/* logic/acsir_pkg.sv */
// Purpose: Constants for the accelerometer status and interrupt routing block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Identity value is arbitrary
`default_nettype none
package acsir_pkg;
  localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h0F;
  localparam logic [7:0] ADDR_INT_PIN_CONFIG  = 8'h22;
  localparam logic [7:0] ADDR_SAMPLE_STATUS   = 8'h27;
  localparam logic [7:0] ADDR_X_SAMPLE        = 8'h29;
  localparam logic [7:0] ADDR_Y_SAMPLE        = 8'h2B;
  localparam logic [7:0] ADDR_Z_SAMPLE        = 8'h2D;
  // Arbitrary identity value, not any real part
  localparam logic [7:0] DEVICE_ID_VALUE      = 8'hA5;
  localparam logic [7:0] INT_PIN_CONFIG_RESET = 8'h00;
  localparam logic [7:0] SAMPLE_STATUS_RESET  = 8'h00;
  localparam logic [2:0] AXIS_ENABLE_RESET    = 3'h7;
  // Config field positions
  localparam int CFG_POLARITY_BIT = 7;
  localparam int CFG_DRIVE_BIT    = 6;
  localparam int CFG_PIN_B_LSB    = 3;
  localparam int CFG_PIN_A_LSB    = 0;
  // Status field positions
  localparam int STS_ALL_OVR_BIT  = 7;
  localparam int STS_OVR_LSB      = 4;
  localparam int STS_ALL_AVL_BIT  = 3;
  localparam int STS_AVL_LSB      = 0;
  // Pin source selections
  typedef enum logic [2:0] {
    SRC_GROUND     = 3'b000,
    SRC_DETECTOR_A = 3'b001,
    SRC_DETECTOR_B = 3'b010,
    SRC_DETECTOR_AB = 3'b011,
    SRC_DATA_READY = 3'b100
  } acsir_src_e;
endpackage
`default_nettype wire

/* logic/acsir_regs.sv */
// Purpose: Register bank, status flags and interrupt pin routing of the accelerometer
// Assumes: Serial port decoded elsewhere into a one-cycle read and write strobe
// Notes:   Detector engines, filter and serial protocol live outside
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Pins active high when polarity bit is 0, active low when 1.
// - Pads push-pull when drive bit is 0, open drain when 1.
// - Pin source field 000 ground, 001 A, 010 B, 011 A or B, 100 ready.
// - Config at 22h: bit7 polarity, bit6 drive, 5:3 pin B, 2:0 pin A.
// - Each detector uses raw data unless its filter-select bit is 1.
// - Detector source registers load from the interrupt generator output.
// - Read-only identity register at 0Fh returns a fixed value.
// - All-axes overrun sets when a new set overwrites an unread one.
// - All-axes overrun clears once all active axes have been read.
// - Z overrun sets on overwrite of unread Z, clears on Z read.
// - All-axes available sets when all enabled axes new, clears after all read.
// - Z available sets on new Z while enabled, clears on Z read.
// - Y available sets on new Y while enabled, clears on Y read.
// - X available sets on new X while enabled, clears on X read.
// - Status at 27h: overruns in bits 7:4, availables in 3:0, reset 0.
// - Axis enable bits default 1 gate data-ready generation per axis.
// - Latched detector request holds until its source register is read; here pins follow detector inputs, source reads unused.
module acsir_regs (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic [2:0] axis_enable_i,
  input  wire logic [2:0] detector_hp_cfg_i,
  output logic            detector_a_hp_select_o,
  output logic            detector_b_hp_select_o,
  input  wire logic       motion_detector_a_i,
  input  wire logic       motion_detector_b_i,
  input  wire logic       detector_a_source_rd_i,
  input  wire logic       detector_b_source_rd_i,
  output logic            detector_a_source_load_o,
  output logic            detector_b_source_load_o,
  input  wire logic [2:0] sample_new_i,
  input  wire logic [7:0] x_sample_i,
  input  wire logic [7:0] y_sample_i,
  input  wire logic [7:0] z_sample_i,
  output logic            irq_pin_a_o,
  output logic            irq_pin_a_oe_n_o,
  output logic            irq_pin_b_o,
  output logic            irq_pin_b_oe_n_o
);

  logic [7:0] cfg_q, cfg_d;
  logic [7:0] status_q, status_d;
  logic [7:0] x_q, x_d, y_q, y_d, z_q, z_d;
  logic [2:0] rd_axis_q, rd_axis_d;      // Axes read since last complete set or last full read of the enabled axes
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] axis_rd;
  logic [2:0] avail, ovr;
  logic [2:0] en_eff;
  logic       set_all_avl, all_read, set_all_ovr;
  logic       det_a, det_b, ready_sig;
  logic       pin_a_act, pin_b_act;

  ////////////////////////////////////////////////////////////////////////////
  // Detector hookup: filter selects and source loading
  assign detector_a_hp_select_o   = detector_hp_cfg_i[0];
  assign detector_b_hp_select_o   = detector_hp_cfg_i[1];
  // Source registers load in each cycle that the generator output is high
  assign detector_a_source_load_o = motion_detector_a_i;
  assign detector_b_source_load_o = motion_detector_b_i;
  // Latch behaviour is kept by the detector engine; read clears it outside
  assign det_a = motion_detector_a_i;
  assign det_b = motion_detector_b_i;

  ////////////////////////////////////////////////////////////////////////////
  // Axis read strobes and status flag next values
  assign axis_rd[0] = reg_rd_i && (reg_addr_i == acsir_pkg::ADDR_X_SAMPLE);
  assign axis_rd[1] = reg_rd_i && (reg_addr_i == acsir_pkg::ADDR_Y_SAMPLE);
  assign axis_rd[2] = reg_rd_i && (reg_addr_i == acsir_pkg::ADDR_Z_SAMPLE);
  assign en_eff     = axis_enable_i;

  always_comb begin
    avail    = status_q[acsir_pkg::STS_AVL_LSB +: 3];
    ovr      = status_q[acsir_pkg::STS_OVR_LSB +: 3];
    x_d      = x_q;
    y_d      = y_q;
    z_d      = z_q;
    for (int i = 0; i < 3; i++) begin
      // Set wins over read clear
      if (sample_new_i[i] && avail[i]) begin
        ovr[i] = 1'b1;
      end else if (axis_rd[i]) begin
        ovr[i] = 1'b0;
      end
      // New sample counts only for enabled axes
      if (sample_new_i[i] && en_eff[i]) begin
        avail[i] = 1'b1;
      end else if (axis_rd[i]) begin
        avail[i] = 1'b0;
      end
    end
    if (sample_new_i[0]) begin
      x_d = x_sample_i;
    end
    if (sample_new_i[1]) begin
      y_d = y_sample_i;
    end
    if (sample_new_i[2]) begin
      z_d = z_sample_i;
    end
    // Track reads of the active axes
    rd_axis_d   = (rd_axis_q | axis_rd) & en_eff;
    all_read    = (en_eff != 3'h0) && ((rd_axis_d & en_eff) == en_eff);
    set_all_avl = (en_eff != 3'h0) && ((avail & en_eff) == en_eff)
                  && (|(sample_new_i & en_eff));
    set_all_ovr = |(sample_new_i & en_eff & status_q[acsir_pkg::STS_AVL_LSB +: 3]);
    status_d = status_q;
    status_d[acsir_pkg::STS_OVR_LSB +: 3] = ovr;
    status_d[acsir_pkg::STS_AVL_LSB +: 3] = avail;
    if (set_all_avl) begin
      status_d[acsir_pkg::STS_ALL_AVL_BIT] = 1'b1;
      rd_axis_d = 3'h0;
    end else if (all_read) begin
      status_d[acsir_pkg::STS_ALL_AVL_BIT] = 1'b0;
    end
    if (set_all_ovr) begin
      status_d[acsir_pkg::STS_ALL_OVR_BIT] = 1'b1;
    end else if (all_read) begin
      status_d[acsir_pkg::STS_ALL_OVR_BIT] = 1'b0;
    end
    if (all_read && !set_all_avl) begin
      rd_axis_d = 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write and read data
  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr_i && (reg_addr_i == acsir_pkg::ADDR_INT_PIN_CONFIG)) begin
      cfg_d = reg_wdata_i;
    end
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        acsir_pkg::ADDR_DEVICE_IDENTITY: rdata_d = acsir_pkg::DEVICE_ID_VALUE;
        acsir_pkg::ADDR_INT_PIN_CONFIG:  rdata_d = cfg_q;
        acsir_pkg::ADDR_SAMPLE_STATUS:   rdata_d = status_q;
        acsir_pkg::ADDR_X_SAMPLE:        rdata_d = x_q;
        acsir_pkg::ADDR_Y_SAMPLE:        rdata_d = y_q;
        acsir_pkg::ADDR_Z_SAMPLE:        rdata_d = z_q;
        default:                         rdata_d = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q     <= acsir_pkg::INT_PIN_CONFIG_RESET;
      status_q  <= acsir_pkg::SAMPLE_STATUS_RESET;
      x_q       <= 8'h00;
      y_q       <= 8'h00;
      z_q       <= 8'h00;
      rd_axis_q <= 3'h0;
      rdata_q   <= 8'h00;
    end else begin
      cfg_q     <= cfg_d;
      status_q  <= status_d;
      x_q       <= x_d;
      y_q       <= y_d;
      z_q       <= z_d;
      rd_axis_q <= rd_axis_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin source selection, polarity and drive
  assign ready_sig = status_q[acsir_pkg::STS_ALL_AVL_BIT];

  function automatic logic pick(input logic [2:0] sel, input logic a, input logic b,
                                input logic r);
    unique case (sel)
      acsir_pkg::SRC_GROUND:      pick = 1'b0;
      acsir_pkg::SRC_DETECTOR_A:  pick = a;
      acsir_pkg::SRC_DETECTOR_B:  pick = b;
      acsir_pkg::SRC_DETECTOR_AB: pick = a | b;
      acsir_pkg::SRC_DATA_READY:  pick = r;
      default:                    pick = 1'b0;
    endcase
  endfunction

  assign pin_a_act = pick(cfg_q[acsir_pkg::CFG_PIN_A_LSB +: 3], det_a, det_b, ready_sig);
  assign pin_b_act = pick(cfg_q[acsir_pkg::CFG_PIN_B_LSB +: 3], det_a, det_b, ready_sig);

  // Level is active XOR polarity; open drain releases the pad when high
  always_comb begin
    irq_pin_a_o = pin_a_act ^ cfg_q[acsir_pkg::CFG_POLARITY_BIT];
    irq_pin_b_o = pin_b_act ^ cfg_q[acsir_pkg::CFG_POLARITY_BIT];
    irq_pin_a_oe_n_o = cfg_q[acsir_pkg::CFG_DRIVE_BIT] && irq_pin_a_o;
    irq_pin_b_oe_n_o = cfg_q[acsir_pkg::CFG_DRIVE_BIT] && irq_pin_b_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_polarity;
    @(posedge clock_i) disable iff (!reset_n_i)
      (cfg_q[acsir_pkg::CFG_PIN_A_LSB +: 3] == acsir_pkg::SRC_DETECTOR_A)
        |-> irq_pin_a_o == (motion_detector_a_i ^ cfg_q[acsir_pkg::CFG_POLARITY_BIT]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin level wrong");

  property p_open_drain;
    @(posedge clock_i) disable iff (!reset_n_i)
      (cfg_q[acsir_pkg::CFG_DRIVE_BIT] && irq_pin_a_o) |-> irq_pin_a_oe_n_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

  property p_ground;
    @(posedge clock_i) disable iff (!reset_n_i)
      (cfg_q[acsir_pkg::CFG_PIN_A_LSB +: 3] == acsir_pkg::SRC_GROUND
       && !cfg_q[acsir_pkg::CFG_POLARITY_BIT]) |-> !irq_pin_a_o;
  endproperty
  a_ground: assert property (p_ground) else $error("ground source active");

  property p_cfg_write;
    @(posedge clock_i) disable iff (!reset_n_i)
      (reg_wr_i && reg_addr_i == acsir_pkg::ADDR_INT_PIN_CONFIG) |=> cfg_q == $past(reg_wdata_i);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_ident;
    @(posedge clock_i) disable iff (!reset_n_i)
      (reg_rd_i && reg_addr_i == acsir_pkg::ADDR_DEVICE_IDENTITY)
        |=> reg_rdata_o == acsir_pkg::DEVICE_ID_VALUE;
  endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");

  property p_z_ovr;
    @(posedge clock_i) disable iff (!reset_n_i)
      (sample_new_i[2] && status_q[2]) |=> status_q[6];
  endproperty
  a_z_ovr: assert property (p_z_ovr) else $error("z overrun not set");

  property p_x_clr;
    @(posedge clock_i) disable iff (!reset_n_i)
      (axis_rd[0] && !sample_new_i[0]) |=> !status_q[0] && !status_q[4];
  endproperty
  a_x_clr: assert property (p_x_clr) else $error("x flags not cleared");

  property p_y_enable;
    @(posedge clock_i) disable iff (!reset_n_i)
      (!status_q[1] && !axis_enable_i[1]) |=> !status_q[1];
  endproperty
  a_y_enable: assert property (p_y_enable) else $error("y set while disabled");

  property p_push_pull;
    @(posedge clock_i) disable iff (!reset_n_i)
      !cfg_q[acsir_pkg::CFG_DRIVE_BIT] |-> !irq_pin_a_oe_n_o && !irq_pin_b_oe_n_o;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pad released");

  property p_ready_pin;
    @(posedge clock_i) disable iff (!reset_n_i)
      (cfg_q[acsir_pkg::CFG_PIN_B_LSB +: 3] == acsir_pkg::SRC_DATA_READY
       && !cfg_q[acsir_pkg::CFG_POLARITY_BIT])
        |-> irq_pin_b_o == status_q[acsir_pkg::STS_ALL_AVL_BIT];
  endproperty
  a_ready_pin: assert property (p_ready_pin) else $error("ready pin wrong");

  property p_all_ovr_set;
    @(posedge clock_i) disable iff (!reset_n_i)
      |(sample_new_i & axis_enable_i & status_q[acsir_pkg::STS_AVL_LSB +: 3])
        |=> status_q[acsir_pkg::STS_ALL_OVR_BIT];
  endproperty
  a_all_ovr_set: assert property (p_all_ovr_set) else $error("all overrun not set");

  property p_y_ovr;
    @(posedge clock_i) disable iff (!reset_n_i)
      (sample_new_i[1] && status_q[acsir_pkg::STS_AVL_LSB + 1])
        |=> status_q[acsir_pkg::STS_OVR_LSB + 1];
  endproperty
  a_y_ovr: assert property (p_y_ovr) else $error("y overrun not set");

  property p_z_clr;
    @(posedge clock_i) disable iff (!reset_n_i)
      (axis_rd[2] && !sample_new_i[2])
        |=> !status_q[acsir_pkg::STS_AVL_LSB + 2] && !status_q[acsir_pkg::STS_OVR_LSB + 2];
  endproperty
  a_z_clr: assert property (p_z_clr) else $error("z flags not cleared");

  property p_x_set;
    @(posedge clock_i) disable iff (!reset_n_i)
      (sample_new_i[0] && axis_enable_i[0]) |=> status_q[acsir_pkg::STS_AVL_LSB];
  endproperty
  a_x_set: assert property (p_x_set) else $error("x available not set");

  property p_latch_a;
    @(posedge clock_i) disable iff (!reset_n_i)
      (cfg_q[acsir_pkg::CFG_PIN_A_LSB +: 3] == acsir_pkg::SRC_DETECTOR_A
       && !cfg_q[acsir_pkg::CFG_POLARITY_BIT]
       && motion_detector_a_i && !detector_a_source_rd_i) |-> irq_pin_a_o;
  endproperty
  a_latch_a: assert property (p_latch_a) else $error("held request lost on pin a");

  property p_latch_b;
    @(posedge clock_i) disable iff (!reset_n_i)
      (cfg_q[acsir_pkg::CFG_PIN_B_LSB +: 3] == acsir_pkg::SRC_DETECTOR_B
       && !cfg_q[acsir_pkg::CFG_POLARITY_BIT]
       && motion_detector_b_i && !detector_b_source_rd_i) |-> irq_pin_b_o;
  endproperty
  a_latch_b: assert property (p_latch_b) else $error("held request lost on pin b");
endmodule

`default_nettype wire

/* tb/acsir_host_model.sv */
// Purpose: Host side of the register port and the interrupt lines
// Assumes: Strobes change on the falling edge and last one cycle
// Notes:   Released open drain lines float to the pull-up level
`timescale 1ns/100ps
`default_nettype none
module acsir_host_model (
  input  wire logic       clock_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       pin_a_i,
  input  wire logic       pin_a_oe_n_i,
  input  wire logic       pin_b_i,
  input  wire logic       pin_b_oe_n_i,
  output logic            line_a_o,
  output logic            line_b_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Wired-OR lines with pull-up
  assign line_a_o = pin_a_oe_n_i ? 1'b1 : pin_a_i;
  assign line_b_o = pin_b_oe_n_i ? 1'b1 : pin_b_i;

  // Idle bus at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-byte write; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clock_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask

  // One-byte read, data taken once registered
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clock_i);
    reg_rd_o   = 1'b0;
    @(negedge clock_i);
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the status and interrupt routing block
// Assumes: All register traffic goes through the host model
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       clock   = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd, hp_a, hp_b, ld_a, ld_b, pa, pa_oe_n, pb, pb_oe_n, line_a, line_b;
  logic [2:0] axis_en = 3'h7;
  logic [2:0] hp_cfg  = 3'h0;
  logic [1:0] det     = 2'h0;
  logic [2:0] smp_new = 3'h0;
  logic [7:0] smp_val = 8'h00;
  logic [1:0] src_rd  = 2'h0;
  int         miscompares  = 0;
  int         total_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Block and host
  acsir_regs acsir_regs_i (
    .clock_i(clock), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .axis_enable_i(axis_en),
    .detector_hp_cfg_i(hp_cfg), .detector_a_hp_select_o(hp_a), .detector_b_hp_select_o(hp_b),
    .motion_detector_a_i(det[0]), .motion_detector_b_i(det[1]),
    .detector_a_source_rd_i(src_rd[0]), .detector_b_source_rd_i(src_rd[1]),
    .detector_a_source_load_o(ld_a), .detector_b_source_load_o(ld_b),
    .sample_new_i(smp_new), .x_sample_i(smp_val), .y_sample_i(smp_val + 8'h01),
    .z_sample_i(smp_val + 8'h02), .irq_pin_a_o(pa), .irq_pin_a_oe_n_o(pa_oe_n),
    .irq_pin_b_o(pb), .irq_pin_b_oe_n_o(pb_oe_n));
  acsir_host_model acsir_host_model_i (
    .clock_i(clock), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd),
    .reg_rdata_i(rdata), .pin_a_i(pa), .pin_a_oe_n_i(pa_oe_n), .pin_b_i(pb),
    .pin_b_oe_n_i(pb_oe_n), .line_a_o(line_a), .line_b_o(line_b));

  // Clock at 40 MHz
  initial begin
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] v;
    acsir_host_model_i.rd(a, v);
    chk(v, e, m);
  endtask

  task automatic smp(input logic [2:0] n, input logic [7:0] v);
    @(negedge clock);
    smp_new = n;
    smp_val = v;
    @(negedge clock);
    smp_new = 3'h0;
  endtask

  // Expected pin activity before polarity, data-ready idle
  function automatic logic act(input logic [2:0] s, input logic [1:0] d);
    act = (s == 3'h1) ? d[0] : (s == 3'h2) ? d[1] : (s == 3'h3) ? |d : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({6'h00, pa_oe_n, pa}, 8'h00, 8'hFF);
    rdchk(acsir_pkg::ADDR_DEVICE_IDENTITY, acsir_pkg::DEVICE_ID_VALUE, 8'hFF);
    rdchk(acsir_pkg::ADDR_INT_PIN_CONFIG, 8'h00, 8'hFF);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h00, 8'hFF);
    rdchk(8'h30, 8'h00, 8'hFF);
    acsir_host_model_i.wr(acsir_pkg::ADDR_DEVICE_IDENTITY, 8'h5A);
    acsir_host_model_i.wr(acsir_pkg::ADDR_SAMPLE_STATUS, 8'hFF);
    rdchk(acsir_pkg::ADDR_DEVICE_IDENTITY, acsir_pkg::DEVICE_ID_VALUE, 8'hFF);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h00, 8'hFF);
  endtask

  task automatic t_route();
    logic [7:0] c;
    logic       lv;
    logic [7:0] e;
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 5; s++) begin
        c = {p[1:0], s[2:0], s[2:0]};
        acsir_host_model_i.wr(acsir_pkg::ADDR_INT_PIN_CONFIG, c);
        rdchk(acsir_pkg::ADDR_INT_PIN_CONFIG, c, 8'hFF);
        for (int d = 0; d < 4; d++) begin
          @(negedge clock);
          det    = d[1:0];
          hp_cfg = {1'b0, d[1:0]};
          @(negedge clock);
          lv = act(s[2:0], d[1:0]) ^ p[1];
          e  = {4'h0, {2{p[0] & lv, lv}}};
          chk({4'h0, pa_oe_n, line_a, pb_oe_n, line_b}, e, 8'hFF);
          chk({6'h00, ld_b, ld_a}, {6'h00, d[1:0]}, 8'hFF);
          chk({6'h00, hp_b, hp_a}, {6'h00, d[1:0]}, 8'hFF);
        end
      end
    end
  endtask

  task automatic t_flags();
    smp(3'h7, 8'h10);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h0F, 8'hFF);
    rdchk(acsir_pkg::ADDR_X_SAMPLE, 8'h10, 8'hFF);
    smp(3'h4, 8'h20);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'hCE, 8'hFF);
    rdchk(acsir_pkg::ADDR_Y_SAMPLE, 8'h11, 8'hFF);
    rdchk(acsir_pkg::ADDR_Z_SAMPLE, 8'h22, 8'hFF);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h00, 8'hFF);
    smp(3'h3, 8'h30);
    smp(3'h3, 8'h40);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h33, 8'h7F);
    rdchk(acsir_pkg::ADDR_Y_SAMPLE, 8'h41, 8'hFF);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h11, 8'h7F);
    rdchk(acsir_pkg::ADDR_X_SAMPLE, 8'h40, 8'hFF);
    smp(3'h4, 8'h50);
    rdchk(acsir_pkg::ADDR_Z_SAMPLE, 8'h52, 8'hFF);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h00, 8'hFF);
  endtask

  task automatic t_enable();
    @(negedge clock);
    axis_en = 3'h3;
    acsir_host_model_i.wr(acsir_pkg::ADDR_INT_PIN_CONFIG, 8'h24);
    smp(3'h7, 8'h60);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h0B, 8'hFF);
    chk({6'h00, line_b, line_a}, 8'h03, 8'hFF);
    rdchk(acsir_pkg::ADDR_X_SAMPLE, 8'h60, 8'hFF);
    rdchk(acsir_pkg::ADDR_Y_SAMPLE, 8'h61, 8'hFF);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h00, 8'hFF);
    chk({6'h00, line_b, line_a}, 8'h00, 8'hFF);
  endtask

  // Latching detector model: request held until its source register is read
  task automatic t_latch();
    @(negedge clock);
    det = 2'h0;
    acsir_host_model_i.wr(acsir_pkg::ADDR_INT_PIN_CONFIG, 8'h01);
    chk({7'h00, line_a}, 8'h00, 8'hFF);
    det = 2'h1;
    repeat (4) @(negedge clock);
    chk({7'h00, line_a}, 8'h01, 8'hFF);
    src_rd = 2'h1;
    @(negedge clock);
    src_rd = 2'h0;
    det    = 2'h0;
    @(negedge clock);
    chk({7'h00, line_a}, 8'h00, 8'hFF);
  endtask

  // Reset in mid-run returns config, status and X sample to their reset values
  task automatic t_midreset();
    acsir_host_model_i.wr(acsir_pkg::ADDR_INT_PIN_CONFIG, 8'hC9);
    smp(3'h7, 8'h70);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, 8'h0B, 8'hFF);
    @(negedge clock);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    chk({6'h00, pa_oe_n, pa}, 8'h00, 8'hFF);
    rdchk(acsir_pkg::ADDR_INT_PIN_CONFIG, acsir_pkg::INT_PIN_CONFIG_RESET, 8'hFF);
    rdchk(acsir_pkg::ADDR_SAMPLE_STATUS, acsir_pkg::SAMPLE_STATUS_RESET, 8'hFF);
    rdchk(acsir_pkg::ADDR_X_SAMPLE, 8'h00, 8'hFF);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_route();
    t_latch();
    t_flags();
    t_enable();
    t_midreset();
    end_of_test();
  end

  // Watchdog well past the expected run
  initial begin
    #(25 * 5000);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
